//--- inc/i2c_byte_pkg.sv
// shared constants and types for the serial port byte engine
package i2c_byte_pkg;

	// ****************************************************
	// widths and counts
	// ****************************************************
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned BIT_W    = 4;
	localparam logic [3:0]  LAST_DAT = 4'h7;
	localparam logic [3:0]  ACK_BIT  = 4'h8;
	localparam logic [7:0]  CNT_ZERO = 8'h00;
	localparam logic [7:0]  CNT_ONE  = 8'h01;
	localparam logic [3:0]  BIT_ZERO = 4'h0;
	localparam logic [3:0]  BIT_ONE  = 4'h1;

	// ****************************************************
	// sub-phases of one bit time
	// ****************************************************
	localparam logic [2:0] PH_LOW   = 3'h0;
	localparam logic [2:0] PH_REL   = 3'h1;
	localparam logic [2:0] PH_HIGH  = 3'h2;
	localparam logic [2:0] PH_SDAHI = 3'h3;
	localparam logic [2:0] PH_FIN   = 3'h4;
	localparam logic [2:0] PH_SETUP = 3'h5;

	// ****************************************************
	// engine states, one-hot
	// ****************************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_TX   = 5'h02,
		ST_RX   = 5'h04,
		ST_ACK  = 5'h08,
		ST_STOP = 5'h10
	} state_t;

	// ****************************************************
	// carriers
	// ****************************************************
	typedef struct packed {
		logic buffer_full_flag;
		logic ack_status_bit;
		logic serial_event_flag;
		logic write_collision_flag;
		logic receive_overflow_flag;
		logic receive_request_bit;
		logic ack_sequence_request;
		logic stop_request_bit;
		logic bus_free;
		logic busy;
	} status_t;

	typedef struct packed {
		logic scl_oe;
		logic sda_oe;
	} pins_t;

	localparam status_t STATUS_RST = '{default: 1'b0};
	localparam pins_t   PINS_REL   = '{default: 1'b0};

endpackage : i2c_byte_pkg

//--- logic/i2c_master_byte_engine.sv
// master byte engine of a two-wire serial port
`timescale 1ns/1ps

module i2c_master_byte_engine
	import i2c_byte_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// software side
	input  wire logic              buf_wr,
	input  wire logic [BYTE_W-1:0] buf_wdata,
	input  wire logic              buf_rd,
	input  wire logic              rcv_req_set,
	input  wire logic              ack_req_set,
	input  wire logic              stop_req_set,
	input  wire logic              ack_value_bit,
	input  wire logic              write_collision_flag_clear,
	input  wire logic              event_clear,
	input  wire logic              ovf_clear,
	input  wire logic [BYTE_W-1:0] baud_reload,
	output      logic [BYTE_W-1:0] transfer_buffer,
	output      status_t           status,
	// bus pins, open drain
	input  wire logic              scl_in,
	output      logic              scl_out,
	output      logic              scl_oe,
	input  wire logic              sda_in,
	output      logic              sda_out,
	output      logic              sda_oe
);

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	logic scl_m, scl_s, sda_m, sda_s;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			sda_m <= sda_in;
			sda_s <= sda_m;
		end
	end

	// ****************************************************
	// state and sequencing
	// ****************************************************
	state_t            state;
	logic [2:0]        phase;
	logic [BIT_W-1:0]  bitcnt;
	logic [BYTE_W-1:0] shreg;
	logic [BYTE_W-1:0] cnt;
	logic              ack_drive;
	logic              idle, tick, brg_run, brg_load;
	logic              start_tx, start_rx, start_ack, start_stop;
	logic              rx_done;
	pins_t             next_pins, pins;

	assign idle       = (state == ST_IDLE);
	// fixed priority keeps exactly one sequence running
	assign start_tx   = idle && buf_wr;
	assign start_rx   = idle && !buf_wr && rcv_req_set;
	assign start_ack  = idle && !buf_wr && !rcv_req_set && ack_req_set;
	assign start_stop = idle && !buf_wr && !rcv_req_set && !ack_req_set && stop_req_set;

	// generator halts while SCL is released but still held low
	assign brg_run  = !idle && (phase == PH_LOW || phase == PH_HIGH || phase == PH_FIN);
	assign tick     = brg_run && (cnt == CNT_ZERO);
	assign brg_load = start_tx || start_rx || start_ack || tick
		|| (phase == PH_REL && scl_s && !idle)
		|| (state == ST_STOP && phase == PH_SETUP && !sda_s)
		|| (state == ST_STOP && phase == PH_SDAHI && sda_s && scl_s);
	assign rx_done  = (state == ST_RX) && (phase == PH_HIGH) && tick && (bitcnt == LAST_DAT);

	// ****************************************************
	// baud generator
	// ****************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= CNT_ZERO;
		end else if (brg_load) begin
			cnt <= baud_reload;
		end else if (brg_run && cnt != CNT_ZERO) begin
			cnt <= cnt - CNT_ONE;
		end
	end

	// ****************************************************
	// engine state machine
	// ****************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state  <= ST_IDLE;
			phase  <= PH_LOW;
			bitcnt <= BIT_ZERO;
		end else begin
			case (state)
				ST_IDLE: begin
					phase  <= start_stop ? PH_SETUP : PH_LOW;
					bitcnt <= BIT_ZERO;
					if (start_tx)
						state <= ST_TX;
					else if (start_rx)
						state <= ST_RX;
					else if (start_ack)
						state <= ST_ACK;
					else if (start_stop)
						state <= ST_STOP;
				end
				ST_TX, ST_RX, ST_ACK: begin
					case (phase)
						PH_LOW:  if (tick) phase <= PH_REL;
						PH_REL:  if (scl_s) phase <= PH_HIGH;
						PH_HIGH: begin
							if (tick) begin
								phase  <= PH_LOW;
								bitcnt <= bitcnt + BIT_ONE;
								if (state == ST_ACK
									|| (state == ST_TX && bitcnt == ACK_BIT)
									|| rx_done)
									state <= ST_IDLE;
							end
						end
						default: phase <= PH_LOW;
					endcase
				end
				ST_STOP: begin
					case (phase)
						PH_SETUP: if (!sda_s) phase <= PH_LOW;
						PH_LOW:   if (tick) phase <= PH_REL;
						PH_REL:   if (scl_s) phase <= PH_HIGH;
						PH_HIGH:  if (tick) phase <= PH_SDAHI;
						PH_SDAHI: if (sda_s && scl_s) phase <= PH_FIN;
						PH_FIN:   if (tick) state <= ST_IDLE;
						default:  phase <= PH_SETUP;
					endcase
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************
	// shift register
	// ****************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			shreg <= CNT_ZERO;
		end else if (start_tx) begin
			shreg <= buf_wdata;
		end else if (state == ST_TX && phase == PH_HIGH && tick) begin
			shreg <= {shreg[BYTE_W-2:0], 1'b0};
		end else if (state == ST_RX && phase == PH_REL && scl_s) begin
			shreg <= {shreg[BYTE_W-2:0], sda_s};
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			ack_drive <= 1'b0;
		else if (start_ack)
			ack_drive <= !ack_value_bit;
	end

	// ****************************************************
	// transfer buffer and flags
	// ****************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			transfer_buffer <= CNT_ZERO;
		end else if (start_tx) begin
			transfer_buffer <= buf_wdata;
		end else if (rx_done) begin
			transfer_buffer <= shreg;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			status <= STATUS_RST;
		end else begin
			status.busy <= !idle;
			// full flag: set wins over the read that clears it
			if (start_tx || rx_done)
				status.buffer_full_flag <= 1'b1;
			else if (state == ST_TX && phase == PH_HIGH && tick && bitcnt == LAST_DAT)
				status.buffer_full_flag <= 1'b0;
			else if (buf_rd && state != ST_TX)
				status.buffer_full_flag <= 1'b0;
			if (state == ST_TX && phase == PH_REL && scl_s && bitcnt == ACK_BIT)
				status.ack_status_bit <= sda_s;
			if ((state == ST_TX && phase == PH_HIGH && tick && bitcnt == ACK_BIT)
				|| rx_done || (state == ST_ACK && phase == PH_HIGH && tick)
				|| (state == ST_STOP && phase == PH_FIN && tick))
				status.serial_event_flag <= 1'b1;
			else if (event_clear)
				status.serial_event_flag <= 1'b0;
			// only software ever clears the collision flag
			if (buf_wr && !idle)
				status.write_collision_flag <= 1'b1;
			else if (write_collision_flag_clear)
				status.write_collision_flag <= 1'b0;
			if (rx_done && status.buffer_full_flag)
				status.receive_overflow_flag <= 1'b1;
			else if (ovf_clear)
				status.receive_overflow_flag <= 1'b0;
			if (start_rx)
				status.receive_request_bit <= 1'b1;
			else if (rx_done)
				status.receive_request_bit <= 1'b0;
			if (start_ack)
				status.ack_sequence_request <= 1'b1;
			else if (state == ST_ACK && phase == PH_HIGH && tick)
				status.ack_sequence_request <= 1'b0;
			if (start_stop)
				status.stop_request_bit <= 1'b1;
			else if (state == ST_STOP && phase == PH_FIN && tick)
				status.stop_request_bit <= 1'b0;
			if (state == ST_STOP && phase == PH_SDAHI && sda_s && scl_s)
				status.bus_free <= 1'b1;
			else if (start_tx)
				status.bus_free <= 1'b0;
		end
	end

	// ****************************************************
	// pin drive
	// ****************************************************
	always_comb begin
		next_pins = PINS_REL;
		// idle keeps SCL low; the bus is only let go by a stop
		next_pins.scl_oe = !status.bus_free;
		case (state)
			ST_TX: begin
				next_pins.scl_oe = (phase == PH_LOW);
				next_pins.sda_oe = (bitcnt != ACK_BIT) && !shreg[BYTE_W-1];
			end
			ST_RX:  next_pins.scl_oe = (phase == PH_LOW);
			ST_ACK: begin
				next_pins.scl_oe = (phase == PH_LOW);
				next_pins.sda_oe = ack_drive;
			end
			ST_STOP: begin
				next_pins.scl_oe = (phase == PH_SETUP || phase == PH_LOW);
				next_pins.sda_oe = (phase != PH_SDAHI && phase != PH_FIN);
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			pins <= PINS_REL;
		else
			pins <= next_pins;
	end

	assign scl_oe  = pins.scl_oe;
	assign sda_oe  = pins.sda_oe;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_tx_last_fall;
		state == ST_TX && phase == PH_HIGH && tick && bitcnt == ACK_BIT;
	endsequence

	sequence s_stop_end;
		state == ST_STOP && phase == PH_FIN && tick;
	endsequence

	property p_wr_start;
		start_tx |=> status.buffer_full_flag && state == ST_TX && shreg == $past(buf_wdata);
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("write did not start send");

	property p_write_collision_flag;
		buf_wr && !idle |=> status.write_collision_flag && $stable(transfer_buffer);
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy write not refused");

	property p_bf_clear;
		state == ST_TX && phase == PH_HIGH && tick && bitcnt == LAST_DAT
			|=> !status.buffer_full_flag ##1 !sda_oe;
	endproperty
	a_bf_clear: assert property (p_bf_clear) else $error("full or SDA not released");

	property p_tx_end;
		s_tx_last_fall |=> idle && status.serial_event_flag ##1 scl_oe;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("ninth clock end wrong");

	property p_rx_ignore;
		!idle && rcv_req_set && state != ST_RX |=> !status.receive_request_bit;
	endproperty
	a_rx_ignore: assert property (p_rx_ignore) else $error("receive taken while busy");

	property p_rx_ovf;
		rx_done && status.buffer_full_flag |=> status.receive_overflow_flag && idle;
	endproperty
	a_rx_ovf: assert property (p_rx_ovf) else $error("overflow missed");

	property p_rd_clear;
		buf_rd && state == ST_IDLE |=> !status.buffer_full_flag;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read left full set");

	property p_suspend;
		!idle && phase == PH_REL && !scl_s |=> $stable(cnt);
	endproperty
	a_suspend: assert property (p_suspend) else $error("generator ran while stretched");

	property p_stop_end;
		s_stop_end |=> !status.stop_request_bit && status.serial_event_flag && status.bus_free;
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("stop end wrong");

	property p_onehot;
		$onehot(state);
	endproperty
	a_onehot: assert property (p_onehot) else $error("state not one-hot");

endmodule : i2c_master_byte_engine

//--- test/i2c_slave_model.sv
// slave device model facing the byte engine on the two-wire bus
`timescale 1ns/1ps

module i2c_slave_model (
	// clock
	input  wire logic       clk,
	// bus wires and own drive, high = pull low
	input  wire logic       scl,
	input  wire logic       sda,
	output      logic       scl_oe,
	output      logic       sda_oe,
	// test control
	input  wire logic       arm,
	input  wire logic       send,
	input  wire logic       nack,
	input  wire logic       stretch,
	input  wire logic [7:0] tx_byte,
	output      logic [7:0] rx_byte,
	output      logic       last_sda
);
	logic       scl_q;
	logic [3:0] cnt;
	logic [3:0] hold;

	// ******************************
	// bit handling on sampled edges
	// ******************************
	always_ff @(posedge clk) begin
		scl_q <= scl;
		if (arm) begin
			cnt    <= 4'h0;
			sda_oe <= send & ~tx_byte[7];
		end else if (scl & ~scl_q) begin
			cnt      <= cnt + 4'h1;
			last_sda <= sda;
			if (cnt < 4'h8) rx_byte <= {rx_byte[6:0], sda};
		end else if (~scl & scl_q) begin
			// data changes only while scl is low
			if (send) sda_oe <= (cnt < 4'h8) & ~tx_byte[3'h7 - cnt[2:0]];
			else sda_oe <= (cnt == 4'h8) & ~nack;
		end
	end

	// stretch: hold scl low well beyond one baud period
	always_ff @(posedge clk) begin
		if (arm) hold <= 4'h0;
		else if (stretch & ~scl & scl_q) hold <= 4'hC;
		else if (hold != 4'h0) hold <= hold - 4'h1;
	end
	assign scl_oe = (hold != 4'h0);
endmodule : i2c_slave_model

//--- test/i2c_master_byte_engine_test.sv
// self-checking bench for the serial port byte engine
`timescale 1ns/1ps

module i2c_master_byte_engine_test
	import i2c_byte_pkg::*;
;
	localparam int RD = 0, RCV = 1, ACK = 2, STP = 3, WCL = 4, EVC = 5, OVC = 6, ARM = 7;
	logic       clk = 1'b0, nrst = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0;
	logic       rcv_req_set = 1'b0, ack_req_set = 1'b0, stop_req_set = 1'b0;
	logic       ack_value_bit = 1'b0, write_collision_flag_clear = 1'b0, event_clear = 1'b0;
	logic       ovf_clear = 1'b0, arm = 1'b1, send = 1'b0, nack = 1'b0, stretch = 1'b0;
	logic [7:0] buf_wdata = 8'h00, baud_reload = 8'h03, tx_byte = 8'h00;
	logic [7:0] transfer_buffer, rx_byte;
	status_t    status;
	logic       scl_in, sda_in, scl_oe, sda_oe, m_scl_oe, m_sda_oe, last_sda;
	int         n_fail = 0, samples_checked = 0;

	// open drain wires with pull-ups
	assign scl_in = ~(scl_oe | m_scl_oe);
	assign sda_in = ~(sda_oe | m_sda_oe);
	always #25 clk = ~clk;

	i2c_master_byte_engine i_dut (.clk(clk), .nrst(nrst), .buf_wr(buf_wr),
		.buf_wdata(buf_wdata), .buf_rd(buf_rd), .rcv_req_set(rcv_req_set),
		.ack_req_set(ack_req_set), .stop_req_set(stop_req_set),
		.ack_value_bit(ack_value_bit), .write_collision_flag_clear(write_collision_flag_clear),
		.event_clear(event_clear), .ovf_clear(ovf_clear), .baud_reload(baud_reload),
		.transfer_buffer(transfer_buffer), .status(status), .scl_in(scl_in),
		.scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe));

	i2c_slave_model i_slave (.clk(clk), .scl(scl_in), .sda(sda_in), .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe), .arm(arm), .send(send), .nack(nack), .stretch(stretch),
		.tx_byte(tx_byte), .rx_byte(rx_byte), .last_sda(last_sda));

	// ******************************
	// access tasks
	// ******************************
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic req(input int k);
		@(posedge clk);
		case (k)
			RD: buf_rd <= 1'b1;
			RCV: rcv_req_set <= 1'b1;
			ACK: ack_req_set <= 1'b1;
			STP: stop_req_set <= 1'b1;
			WCL: write_collision_flag_clear <= 1'b1;
			EVC: event_clear <= 1'b1;
			OVC: ovf_clear <= 1'b1;
			default: arm <= 1'b1;
		endcase
		@(posedge clk);
		{buf_rd, rcv_req_set, ack_req_set, stop_req_set} <= 4'h0;
		{write_collision_flag_clear, event_clear, ovf_clear, arm} <= 4'h0;
	endtask : req

	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		buf_wr <= 1'b1;
		buf_wdata <= d;
		@(posedge clk);
		buf_wr <= 1'b0;
	endtask : wr

	// bounded wait for completion, then software clears the event
	task automatic wait_evt();
		int i;
		i = 0;
		while (status.serial_event_flag !== 1'b1 && i < 3000) begin
			@(negedge clk);
			i++;
		end
		// busy is registered from the state, so it drops one cycle after the event
		@(negedge clk);
		chk("event", 10'h001, status.serial_event_flag);
		chk("busy", 10'h000, status.busy);
		req(EVC);
	endtask : wait_evt

	task automatic results();
		if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	// ******************************
	// tests
	// ******************************
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		arm <= 1'b0;
		@(negedge clk);
		chk("status", STATUS_RST, status);
		chk("buffer", 10'h000, transfer_buffer);
		// address byte, acknowledged, with refused requests mid-byte
		req(ARM);
		wr(8'hA5);
		@(negedge clk);
		chk("full", 10'h001, status.buffer_full_flag);
		req(RCV);
		wr(8'h11);
		repeat (2) @(negedge clk);
		chk("rcv ignored", 10'h000, status.receive_request_bit);
		chk("write_collision_flag tx", 10'h001, status.write_collision_flag);
		chk("buffer tx", 10'h0A5, transfer_buffer);
		wait_evt();
		chk("slave rx", 10'h0A5, rx_byte);
		chk("ack_status_bit", 10'h000, status.ack_status_bit);
		chk("full tx", 10'h000, status.buffer_full_flag);
		chk("scl held", 10'h000, scl_in);
		chk("sda free", 10'h001, sda_in);
		req(WCL);
		// data byte refused, slave stretches the clock
		nack <= 1'b1;
		stretch <= 1'b1;
		req(ARM);
		wr(8'h3C);
		wait_evt();
		chk("slave rx2", 10'h03C, rx_byte);
		chk("nackstat", 10'h001, status.ack_status_bit);
		stretch <= 1'b0;
		// receive a byte, write mid-byte is refused
		send <= 1'b1;
		tx_byte <= 8'h96;
		req(ARM);
		req(RCV);
		wr(8'h22);
		@(negedge clk);
		chk("write_collision_flag rx", 10'h001, status.write_collision_flag);
		chk("buffer rx", 10'h03C, transfer_buffer);
		wait_evt();
		chk("rx data", 10'h096, transfer_buffer);
		chk("full rx", 10'h001, status.buffer_full_flag);
		chk("rcv done", 10'h000, status.receive_request_bit);
		chk("scl rx", 10'h000, scl_in);
		req(WCL);
		// second byte without a read overflows
		tx_byte <= 8'h5A;
		req(ARM);
		req(RCV);
		wait_evt();
		chk("ovf", 10'h001, status.receive_overflow_flag);
		chk("rx data2", 10'h05A, transfer_buffer);
		req(OVC);
		req(RD);
		@(negedge clk);
		chk("full rd", 10'h000, status.buffer_full_flag);
		chk("ovf clr", 10'h000, status.receive_overflow_flag);
		// acknowledge sequence, not-acknowledge then acknowledge
		for (int v = 1; v >= 0; v--) begin
			ack_value_bit <= v[0];
			req(ACK);
			wr(8'h33);
			@(negedge clk);
			chk("write_collision_flag ack", 10'h001, status.write_collision_flag);
			wait_evt();
			chk("ack bit", {9'h000, v[0]}, last_sda);
			chk("ack req", 10'h000, status.ack_sequence_request);
			chk("scl ack", 10'h000, scl_in);
			chk("buffer ack", 10'h05A, transfer_buffer);
			req(WCL);
		end
		// stop sequence
		req(STP);
		wr(8'h44);
		repeat (2) @(negedge clk);
		chk("stop sda", 10'h000, sda_in);
		chk("stop scl", 10'h000, scl_in);
		chk("write_collision_flag stop", 10'h001, status.write_collision_flag);
		wait_evt();
		chk("bus free", 10'h001, status.bus_free);
		chk("stop req", 10'h000, status.stop_request_bit);
		results();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule : i2c_master_byte_engine_test
